// ### hw/gpio_pad_pkg.sv
// Purpose: shared constants and types for the pad control block
// Assumes: 10 MHz system clock, synchronous active-low reset
// Notes: drive modes follow the seven pad configurations plus off
package gpio_pad_pkg;

    localparam int PIN_COUNT     = 14;
    localparam int SRC_COUNT     = 4;
    localparam int SEL_W         = 2;
    localparam int MODE_W        = 3;

    // drive mode codes
    localparam logic [2:0] MODE_OFF      = 3'h0;
    localparam logic [2:0] MODE_WEAK_UP  = 3'h1;
    localparam logic [2:0] MODE_WEAK_DN  = 3'h2;
    localparam logic [2:0] MODE_OD_LOW   = 3'h3;
    localparam logic [2:0] MODE_OD_HIGH  = 3'h4;
    localparam logic [2:0] MODE_STRONG   = 3'h5;
    localparam logic [2:0] MODE_WEAK_ALL = 3'h6;
    localparam logic [2:0] MODE_IN_ONLY  = 3'h7;

    localparam logic [1:0] SEL_PORT      = 2'h0;
    localparam logic [1:0] SEL_I2C       = 2'h1;

    // per-pin configuration word
    typedef struct packed {
        logic [2:0] mode;
        logic       thresh_lvttl;
        logic       in_en;
        logic       out_en;
        logic       slew_slow;
        logic [1:0] sel;
    } pin_cfg_s;

    localparam pin_cfg_s CFG_RESET = '{mode: 3'h0, thresh_lvttl: 1'b0, in_en: 1'b0,
                                       out_en: 1'b0, slew_slow: 1'b0, sel: 2'h0};

    // pad-facing controls for one pin
    typedef struct packed {
        logic strong_up;
        logic strong_dn;
        logic weak_up;
        logic weak_dn;
        logic in_buf_en;
        logic thresh_lvttl;
        logic slew_slow;
        logic out_val;
    } pad_ctl_s;

    localparam pad_ctl_s PAD_OFF = '{default: 1'b0};

endpackage

// ### hw/gpio_pad_control.sv
// Purpose: per-pin drive, threshold, buffer, slew and source control, with one hold for all pins
// Assumes: all inputs synchronous to sys_clk; resetn synchronous active low
// Notes: pad_ctl drives analog pad cells; pad_in comes back from pads
//        hold wins over writes; new settings show once hold drops
`timescale 1ns/1ns
`default_nettype none

// How it works
// - mode field picks input only, weak/strong pull mixes, or open drain.
// - threshold bit per pin picks CMOS or LVTTL input levels.
// - in_en and out_en gate buffers independent of mode.
// - hold freezes the last pad controls through deep sleep until released.
// - slew bit per pin selects slow edges.
// - reset and unconfigured pins give no drive and no input.
// - per-pin select routes one source out and its input back.
// - I2C selection forces open-drain low drive.
// - fourteen pins: ten plain plus I2C and debug pins usable as GPIO.
module gpio_pad_control #(
    parameter int PINS = gpio_pad_pkg::PIN_COUNT,
    parameter int SRCS = gpio_pad_pkg::SRC_COUNT
) (
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    input  wire logic                          cfg_we,
    input  wire logic [3:0]                    cfg_pin,
    input  wire gpio_pad_pkg::pin_cfg_s        cfg_wdata,
    input  wire logic                          hold_en,
    input  wire logic [PINS*SRCS-1:0]          src_out,
    input  wire logic [PINS-1:0]               pad_in,
    output var  gpio_pad_pkg::pad_ctl_s [PINS-1:0] pad_ctl,
    output var  logic [PINS*SRCS-1:0]          src_in,
    output var  logic [PINS-1:0]               cfg_done
);

    gpio_pad_pkg::pin_cfg_s [PINS-1:0] cfg_reg;
    gpio_pad_pkg::pin_cfg_s [PINS-1:0] cfg_next;
    logic [PINS-1:0]                   done_reg;
    logic [PINS-1:0]                   done_next;
    gpio_pad_pkg::pad_ctl_s [PINS-1:0] pad_reg;
    gpio_pad_pkg::pad_ctl_s [PINS-1:0] pad_next;
    logic [PINS*SRCS-1:0]              src_in_reg;
    logic [PINS*SRCS-1:0]              src_in_next;
    logic [PINS-1:0]                   pin_out;

    // pad controls for one pin from its config and chosen output bit
    function automatic gpio_pad_pkg::pad_ctl_s decode(input gpio_pad_pkg::pin_cfg_s c,
                                                     input logic o);
        gpio_pad_pkg::pad_ctl_s p;
        logic [2:0]             m;
        p = gpio_pad_pkg::PAD_OFF;
        m = c.mode;
        // an I2C line may only pull low
        if (c.sel == gpio_pad_pkg::SEL_I2C)
            m = gpio_pad_pkg::MODE_OD_LOW;
        p.in_buf_en    = c.in_en;
        p.thresh_lvttl = c.thresh_lvttl;
        p.slew_slow    = c.slew_slow;
        p.out_val      = o;
        // one side per output level: both strong sides would crowbar the pad
        if (c.out_en)
        begin
            unique case (m)
                gpio_pad_pkg::MODE_OFF, gpio_pad_pkg::MODE_IN_ONLY:
                begin
                    p.strong_up = 1'b0;
                end
                gpio_pad_pkg::MODE_WEAK_UP:
                begin
                    p.weak_up   = o;
                    p.strong_dn = !o;
                end
                gpio_pad_pkg::MODE_WEAK_DN:
                begin
                    p.strong_up = o;
                    p.weak_dn   = !o;
                end
                gpio_pad_pkg::MODE_OD_LOW:
                begin
                    p.strong_dn = !o;
                end
                gpio_pad_pkg::MODE_OD_HIGH:
                begin
                    p.strong_up = o;
                end
                gpio_pad_pkg::MODE_STRONG:
                begin
                    p.strong_up = o;
                    p.strong_dn = !o;
                end
                gpio_pad_pkg::MODE_WEAK_ALL:
                begin
                    p.weak_up = o;
                    p.weak_dn = !o;
                end
            endcase
        end
        return p;
    endfunction

    // bit of pin i's selected source in the flat source buses
    function automatic int src_index(input int         i,
                                     input logic [1:0] s);
        return i*SRCS + int'(s);
    endfunction

    // configuration storage, one word per pin
    always_comb
    begin
        cfg_next  = cfg_reg;
        done_next = done_reg;
        if (cfg_we && (int'(cfg_pin) < PINS))
        begin
            cfg_next[cfg_pin]  = cfg_wdata;
            done_next[cfg_pin] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            cfg_reg  <= {PINS{gpio_pad_pkg::CFG_RESET}};
            done_reg <= '0;
        end
        else
        begin
            cfg_reg  <= cfg_next;
            done_reg <= done_next;
        end
    end

    // output bit chosen by each pin's source select
    always_comb
    begin
        pin_out = '0;
        for (int i = 0; i < PINS; i++)
        begin
            pin_out[i] = src_out[src_index(i, cfg_reg[i].sel)];
        end
    end

    // pad controls; hold keeps the last ones through deep sleep
    always_comb
    begin
        pad_next = pad_reg;
        for (int i = 0; i < PINS; i++)
        begin
            if (!hold_en)
            begin
                if (done_reg[i])
                    pad_next[i] = decode(cfg_reg[i], pin_out[i]);
                else
                    pad_next[i] = gpio_pad_pkg::PAD_OFF;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pad_reg <= {PINS{gpio_pad_pkg::PAD_OFF}};
        end
        else
        begin
            pad_reg <= pad_next;
        end
    end

    // input return path: pad level to the selected consumer only
    always_comb
    begin
        src_in_next = '0;
        for (int i = 0; i < PINS; i++)
        begin
            if (done_reg[i] && cfg_reg[i].in_en)
                src_in_next[src_index(i, cfg_reg[i].sel)] = pad_in[i];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            src_in_reg <= '0;
        end
        else
        begin
            src_in_reg <= src_in_next;
        end
    end

    assign pad_ctl  = pad_reg;
    assign src_in   = src_in_reg;
    assign cfg_done = done_reg;

endmodule

`default_nettype wire

// ### verification/pad_board.sv
// Purpose: board side of the pads
// Assumes: every line has a pull-up
// Notes: ext_lo lets another device pull a line low
`timescale 1ns/1ns
`default_nettype none
module pad_board #(parameter int PINS = 14) (
    input  wire gpio_pad_pkg::pad_ctl_s [PINS-1:0] pad_ctl,
    input  wire logic [PINS-1:0]                   ext_lo,
    output var  logic [PINS-1:0]                   pad_in
);
    // a low drive wins, else the pull-up
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            pad_in[i] = !(ext_lo[i] || (!pad_ctl[i].out_val
                && (pad_ctl[i].strong_dn || pad_ctl[i].weak_dn)));
        end
    end
endmodule
`default_nettype wire

// ### verification/gpio_pad_control_monitor.sv
// Purpose: port checks for pad control
// Assumes: pin 0 watched closely
// Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_control_monitor #(parameter int PINS = 14, parameter int SRCS = 4) (
    input wire logic                        sys_clk,
    input wire logic                        resetn,
    input wire logic                        cfg_we,
    input wire logic [3:0]                  cfg_pin,
    input wire gpio_pad_pkg::pin_cfg_s      cfg_wdata,
    input wire logic                        hold_en,
    input wire logic [PINS*SRCS-1:0]        src_out,
    input wire logic [PINS-1:0]             pad_in,
    input wire gpio_pad_pkg::pad_ctl_s [PINS-1:0] pad_ctl,
    input wire logic [PINS*SRCS-1:0]        src_in,
    input wire logic [PINS-1:0]             cfg_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic w0;
    assign w0 = cfg_we && cfg_pin == 4'h0;
    property p_nx(c, e);
        c ##1 !hold_en |=> e;
    endproperty
    a_done_write:
    assert property (cfg_we && cfg_pin < 4'hE |=> cfg_done[$past(cfg_pin)]) else $error("no done");
    a_reset_off:
    assert property (disable iff (1'b0) !resetn |=> pad_ctl == '0 && cfg_done == '0)
        else $error("pin live in reset");
    a_unconfig_off:
    assert property (!cfg_done[0] |-> pad_ctl[0] == '0) else $error("early pin");
    a_hold_frozen:
    assert property (hold_en |=> $stable(pad_ctl)) else $error("hold moved");
    a_i2c_open:
    assert property (p_nx(w0 && cfg_wdata.sel == gpio_pad_pkg::SEL_I2C, !pad_ctl[0].strong_up))
        else $error("i2c high");
    a_in_only:
    assert property (p_nx(w0 && cfg_wdata.mode == gpio_pad_pkg::MODE_IN_ONLY
        && cfg_wdata.sel == gpio_pad_pkg::SEL_PORT, pad_ctl[0][7:4] == 4'h0)) else $error("drive");
    a_out_off:
    assert property (p_nx(w0 && !cfg_wdata.out_en, pad_ctl[0][7:4] == 4'h0)) else $error("out");
    a_thresh_slew:
    assert property (p_nx(w0, pad_ctl[0].thresh_lvttl == $past(cfg_wdata.thresh_lvttl, 2)
        && pad_ctl[0].slew_slow == $past(cfg_wdata.slew_slow, 2))) else $error("thr");
    cover property (hold_en ##1 hold_en);
    cover property (w0 && cfg_wdata.sel == gpio_pad_pkg::SEL_I2C);
    cover property (cfg_done[0] && cfg_done[13]);
endmodule
bind gpio_pad_control gpio_pad_control_monitor #(.PINS(PINS), .SRCS(SRCS)) u_mon (.sys_clk,
    .resetn, .cfg_we, .cfg_pin, .cfg_wdata, .hold_en, .src_out, .pad_in, .pad_ctl, .src_in,
    .cfg_done);
`default_nettype wire

// ### verification/gpio_pad_control_tb.sv
// Purpose: directed checks of pad control
// Assumes: 100 ns clock
// Notes: ends in tally_and_finish
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_control_tb;
    localparam logic [63:0] TBL = 64'h02880820_01404140;
    logic sys_clk = 1'b0, resetn = 1'b0, cfg_we = 1'b0, hold_en = 1'b0;
    logic [3:0] cfg_pin = 4'h0;
    gpio_pad_pkg::pin_cfg_s cfg_wdata = gpio_pad_pkg::CFG_RESET;
    logic [55:0] src_out = '0, src_in;
    logic [13:0] ext_lo = '0, pad_in, cfg_done;
    gpio_pad_pkg::pad_ctl_s [13:0] pad_ctl;
    int fail_count = 0, n_compared = 0;
    always #50 sys_clk = ~sys_clk;
    gpio_pad_control u_gpio_pad_control (.sys_clk, .resetn, .cfg_we, .cfg_pin, .cfg_wdata,
        .hold_en, .src_out, .pad_in, .pad_ctl, .src_in, .cfg_done);
    pad_board #(.PINS(14)) u_pad_board (.pad_ctl, .ext_lo, .pad_in);
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] p, input logic [8:0] c);
        cfg_we <= 1'b1;
        cfg_pin <= p;
        cfg_wdata <= c;
        cyc(1);
        cfg_we <= 1'b0;
        cyc(2);
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        chk({|pad_ctl, |src_in, cfg_done}, 16'h0);
        resetn <= 1'b1;
        cyc(3);
        chk({|pad_ctl, |src_in, cfg_done}, 16'h0);
        src_out[52] <= 1'b1;
        wr(4'hD, 9'h17C);
        chk({cfg_done, pad_ctl[13]}, 24'h20008F);
        cyc(1);
        chk(src_in[55:52], 4'h1);
        ext_lo[13] <= 1'b1;
        wr(4'hE, 9'h1FF);
        chk({cfg_done, src_in[55:52]}, 18'h20000);
        for (int o = 1; o >= 0; o--)
        begin
            for (int m = 0; m < 8; m++)
            begin
                src_out[0] <= 1'(o);
                wr(4'h0, {3'(m), 6'h18});
                chk(pad_ctl[0][7:4], TBL[o*32+m*4+:4]);
            end
        end
        wr(4'h0, 9'h160);
        chk({pad_ctl[0], src_in[3:0]}, 12'h40);
        wr(4'h0, 9'h159);
        chk(pad_ctl[0][7:4], 4'h4);
        src_out[1] <= 1'b1;
        cyc(3);
        chk({pad_ctl[0][7:4], src_in[3:0]}, 8'h02);
        hold_en <= 1'b1;
        wr(4'h0, 9'h198);
        chk(pad_ctl[0][7:4], 4'h0);
        hold_en <= 1'b0;
        cyc(2);
        chk(pad_ctl[0][7:4], 4'h1);
        wr(4'h5, 9'h01B);
        chk(src_in[23:20], 4'h8);
        resetn <= 1'b0;
        cyc(2);
        chk({|pad_ctl, |src_in, cfg_done}, 16'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
